/* File: src/spcd_top.sv */
// serial parameter command decoder: frame check and uart setting update
// What this block does
// - valid command reloads baud, width, stop, parity
// - frame: 55 AA 55, baud msb first, param, sum
// - sum byte is low byte of four-byte sum
// - param: width bits 1:0, stop bit 2, 7:6 zero
// - bit 3 parity on; 5:4 odd/even/mark/space
// - act only when enabled in tcp server/client
`timescale 1ns/1ns
`include "spcd_defs.svh"
module spcd_top (
    input wire logic clock,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic net_byte_valid,
    input wire logic [7:0] net_byte,
    output logic [23:0] uart_baud,
    output logic [3:0] uart_data_bits,
    output logic uart_stop_two,
    output logic uart_parity_en,
    output logic [1:0] uart_parity_type,
    output logic uart_cfg_load
);
    import spcd_pkg::*;

    // ==========================================================
    // declarations
    spcd_reg_if rif ();

    logic ctrl_en_ff;
    logic [2:0] mode_ff;
    logic gate;
    logic clr_cnt;

    spcd_rx_state_e state_ff;
    logic [23:0] baud_sh_ff;
    logic [7:0] prm_ff;
    logic take;
    logic sum_ok;
    logic good;
    logic hdr_bad;
    logic frame_bad;

    logic [3:0] dec_bits;
    logic dec_stop;
    logic dec_pen;
    logic [1:0] dec_ptype;
    logic dec_valid;

    logic [23:0] uart_baud_ff;
    logic [7:0] param_app_ff;
    logic [3:0] uart_data_bits_ff;
    logic uart_stop_two_ff;
    logic uart_parity_en_ff;
    logic [1:0] uart_parity_type_ff;
    logic uart_cfg_load_ff;

    logic [15:0] acc_cnt_ff;
    logic [15:0] rej_cnt_ff;
    logic [15:0] nxt_acc_cnt;
    logic [15:0] nxt_rej_cnt;
    logic [1:0] last_err_ff;
    logic [31:0] rdata;

    // ==========================================================
    // bus slave and parameter decoder
    spcd_ahb_slave u_slave (
        .clock(clock),
        .nrst(nrst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .rif(rif.bus)
    );

    spcd_param_dec u_dec (
        .prm(prm_ff),
        .data_bits(dec_bits),
        .stop_two(dec_stop),
        .parity_en(dec_pen),
        .parity_type(dec_ptype),
        .valid(dec_valid)
    );

    // ==========================================================
    // control register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_en_ff <= 1'b0;
            mode_ff <= `SPCD_RST_MODE;
        end else if (rif.wr && rif.addr == `SPCD_OFS_CTRL) begin
            ctrl_en_ff <= rif.wdata[`SPCD_CTRL_EN];
            mode_ff <= rif.wdata[`SPCD_CTRL_MODE_MSB:`SPCD_CTRL_MODE_LSB];
        end
    end

    assign clr_cnt = rif.wr && rif.addr == `SPCD_OFS_CTRL && rif.wdata[`SPCD_CTRL_CLR];

    // udp and other modes carry raw data, so commands stay untouched there
    assign gate = ctrl_en_ff
        && (mode_ff == `SPCD_MODE_TCPS || mode_ff == `SPCD_MODE_TCPC);

    // ==========================================================
    // frame receiver
    assign take = gate && net_byte_valid;
    assign sum_ok = net_byte == spcd_sum8(baud_sh_ff, prm_ff);
    assign good = take && state_ff == st_sum && sum_ok && dec_valid;
    assign frame_bad = take && state_ff == st_sum && !(sum_ok && dec_valid);
    assign hdr_bad = take && ((state_ff == st_hdr1 && net_byte != `SPCD_HDR1)
        || (state_ff == st_hdr2 && net_byte != `SPCD_HDR2));

    // leaving the gate mid-frame drops the partial frame
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff <= st_hdr0;
        end else if (!gate) begin
            state_ff <= st_hdr0;
        end else if (net_byte_valid) begin
            case (state_ff)
                st_hdr0: begin
                    if (net_byte == `SPCD_HDR0) begin
                        state_ff <= st_hdr1;
                    end
                end
                st_hdr1: begin
                    // a repeated first byte may still start a frame
                    if (net_byte == `SPCD_HDR1) begin
                        state_ff <= st_hdr2;
                    end else if (net_byte == `SPCD_HDR0) begin
                        state_ff <= st_hdr1;
                    end else begin
                        state_ff <= st_hdr0;
                    end
                end
                st_hdr2: begin
                    if (net_byte == `SPCD_HDR2) begin
                        state_ff <= st_baud2;
                    end else begin
                        state_ff <= st_hdr0;
                    end
                end
                st_baud2: state_ff <= st_baud1;
                st_baud1: state_ff <= st_baud0;
                st_baud0: state_ff <= st_param;
                st_param: state_ff <= st_sum;
                st_sum: state_ff <= st_hdr0;
                default: state_ff <= st_hdr0;
            endcase
        end
    end

    // baud arrives most significant byte first
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            baud_sh_ff <= 24'h00_0000;
        end else if (take && (state_ff == st_baud2 || state_ff == st_baud1
            || state_ff == st_baud0)) begin
            baud_sh_ff <= {baud_sh_ff[15:0], net_byte};
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prm_ff <= 8'h00;
        end else if (take && state_ff == st_param) begin
            prm_ff <= net_byte;
        end
    end

    // ==========================================================
    // applied uart settings
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            uart_baud_ff <= `SPCD_RST_BAUD;
            param_app_ff <= `SPCD_RST_PARAM;
            uart_data_bits_ff <= `SPCD_BITS8;
            uart_stop_two_ff <= 1'b0;
            uart_parity_en_ff <= 1'b0;
            uart_parity_type_ff <= 2'h0;
        end else if (good) begin
            uart_baud_ff <= baud_sh_ff;
            param_app_ff <= prm_ff;
            uart_data_bits_ff <= dec_bits;
            uart_stop_two_ff <= dec_stop;
            uart_parity_en_ff <= dec_pen;
            uart_parity_type_ff <= dec_ptype;
        end
    end

    // one-cycle strobe so the uart reloads its divider once
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            uart_cfg_load_ff <= 1'b0;
        end else begin
            uart_cfg_load_ff <= good;
        end
    end

    // ==========================================================
    // statistics
    // an event in the clearing cycle still counts as one
    always_comb begin
        nxt_acc_cnt = (clr_cnt ? 16'h0000 : acc_cnt_ff) + {15'h0000, good};
        nxt_rej_cnt = (clr_cnt ? 16'h0000 : rej_cnt_ff) + {15'h0000, frame_bad || hdr_bad};
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acc_cnt_ff <= 16'h0000;
            rej_cnt_ff <= 16'h0000;
        end else begin
            acc_cnt_ff <= nxt_acc_cnt;
            rej_cnt_ff <= nxt_rej_cnt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            last_err_ff <= `SPCD_ERR_NONE;
        end else if (hdr_bad) begin
            last_err_ff <= `SPCD_ERR_HDR;
        end else if (frame_bad) begin
            last_err_ff <= sum_ok ? `SPCD_ERR_FIELD : `SPCD_ERR_SUM;
        end else if (good) begin
            last_err_ff <= `SPCD_ERR_NONE;
        end
    end

    // ==========================================================
    // register read mux; unmapped offsets read zero
    always_comb begin
        rdata = 32'h0000_0000;
        case (rif.addr)
            `SPCD_OFS_CTRL: begin
                rdata[`SPCD_CTRL_EN] = ctrl_en_ff;
                rdata[`SPCD_CTRL_MODE_MSB:`SPCD_CTRL_MODE_LSB] = mode_ff;
            end
            `SPCD_OFS_BAUD: rdata[23:0] = uart_baud_ff;
            `SPCD_OFS_PARAM: rdata[7:0] = param_app_ff;
            `SPCD_OFS_COUNT: rdata = {rej_cnt_ff, acc_cnt_ff};
            `SPCD_OFS_STAT: begin
                rdata[`SPCD_STAT_ERR_MSB:`SPCD_STAT_ERR_LSB] = last_err_ff;
                rdata[`SPCD_STAT_BUSY] = state_ff != st_hdr0;
                rdata[`SPCD_STAT_GATE] = gate;
            end
            default: rdata = 32'h0000_0000;
        endcase
    end

    assign rif.rdata = rdata;

    // ==========================================================
    // outputs
    assign uart_baud = uart_baud_ff;
    assign uart_data_bits = uart_data_bits_ff;
    assign uart_stop_two = uart_stop_two_ff;
    assign uart_parity_en = uart_parity_en_ff;
    assign uart_parity_type = uart_parity_type_ff;
    assign uart_cfg_load = uart_cfg_load_ff;

    // ==========================================================
    // assertions
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_sum_byte;
        take && state_ff == st_sum;
    endsequence

    sequence s_good_frame;
        s_sum_byte ##0 (net_byte == spcd_sum8(baud_sh_ff, prm_ff)) ##0 dec_valid;
    endsequence

    a_apply_good_frame: assert property (
        s_good_frame |=> uart_cfg_load && uart_baud == $past(baud_sh_ff))
        else $error("valid command did not reload the uart settings");

    a_header_to_baud: assert property (
        (take && state_ff == st_hdr2 && net_byte == `SPCD_HDR2) |=> state_ff == st_baud2)
        else $error("complete header did not start the baud field");

    a_sum_matches: assert property (
        uart_cfg_load |-> $past(net_byte) == spcd_sum8(uart_baud, param_app_ff))
        else $error("settings applied with a wrong checksum");

    a_width_stop_map: assert property (
        uart_cfg_load |-> param_app_ff[`SPCD_RSV_MSB:`SPCD_RSV_LSB] == `SPCD_RSV_ZERO
        && uart_data_bits == (param_app_ff[`SPCD_DW_LSB] ? `SPCD_BITS8 : `SPCD_BITS7)
        && uart_stop_two == param_app_ff[`SPCD_STOP_BIT])
        else $error("data width or stop bits do not follow the parameter byte");

    a_parity_map: assert property (
        uart_parity_en == param_app_ff[`SPCD_PEN_BIT]
        && uart_parity_type == param_app_ff[`SPCD_PT_MSB:`SPCD_PT_LSB])
        else $error("parity outputs do not follow the parameter byte");

    a_gate_blocks: assert property (
        !gate |=> state_ff == st_hdr0 ##0 !uart_cfg_load)
        else $error("command handled while the feature is off");

    a_bad_sum_keeps: assert property (
        (s_sum_byte ##0 !sum_ok) |=> (!uart_cfg_load && $stable(uart_baud)
        && $stable(param_app_ff)) [*2])
        else $error("bad checksum changed the uart settings");
endmodule

/* File: src/spcd_defs.svh */
// constants of the serial parameter command decoder
`ifndef SPCD_DEFS_SVH
`define SPCD_DEFS_SVH

// ==========================================================
// command frame
`define SPCD_HDR0 8'h55
`define SPCD_HDR1 8'hAA
`define SPCD_HDR2 8'h55

// ==========================================================
// parameter byte fields
`define SPCD_DW_MSB 1
`define SPCD_DW_LSB 0
`define SPCD_STOP_BIT 2
`define SPCD_PEN_BIT 3
`define SPCD_PT_MSB 5
`define SPCD_PT_LSB 4
`define SPCD_RSV_MSB 7
`define SPCD_RSV_LSB 6
`define SPCD_DW_7 2'h2
`define SPCD_DW_8 2'h3
`define SPCD_RSV_ZERO 2'h0
`define SPCD_BITS7 4'h7
`define SPCD_BITS8 4'h8

// ==========================================================
// register map, byte offsets
`define SPCD_OFS_CTRL 8'h00
`define SPCD_OFS_BAUD 8'h04
`define SPCD_OFS_PARAM 8'h08
`define SPCD_OFS_COUNT 8'h0C
`define SPCD_OFS_STAT 8'h10
`define SPCD_CTRL_EN 0
`define SPCD_CTRL_CLR 1
`define SPCD_CTRL_MODE_LSB 4
`define SPCD_CTRL_MODE_MSB 6
`define SPCD_STAT_ERR_LSB 0
`define SPCD_STAT_ERR_MSB 1
`define SPCD_STAT_BUSY 4
`define SPCD_STAT_GATE 5

// ==========================================================
// reset values and codes
`define SPCD_RST_BAUD 24'h01_C200
`define SPCD_RST_PARAM 8'h03
`define SPCD_RST_MODE 3'h3
`define SPCD_MODE_TCPC 3'h1
`define SPCD_MODE_TCPS 3'h3
`define SPCD_ERR_NONE 2'h0
`define SPCD_ERR_HDR 2'h1
`define SPCD_ERR_SUM 2'h2
`define SPCD_ERR_FIELD 2'h3
`define SPCD_HSIZE_WORD 3'h2

`endif

/* File: src/spcd_pkg.sv */
// types and shared functions of the serial parameter command decoder
package spcd_pkg;
    typedef enum logic [2:0] {
        st_hdr0, st_hdr1, st_hdr2, st_baud2, st_baud1, st_baud0, st_param, st_sum
    } spcd_rx_state_e;

    typedef enum logic {bus_idle, bus_data} spcd_bus_state_e;

    // low byte of the sum of three baud bytes and the parameter byte
    function automatic logic [7:0] spcd_sum8(input logic [23:0] baud, input logic [7:0] prm);
        logic [7:0] s;
        s = baud[23:16] + baud[15:8] + baud[7:0] + prm;
        return s;
    endfunction
endpackage

/* File: src/spcd_reg_if.sv */
// register access path between the bus slave and the decoder core
`timescale 1ns/1ns
interface spcd_reg_if;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport bus (output wr, output rd, output addr, output wdata, input rdata);
    modport regs (input wr, input rd, input addr, input wdata, output rdata);
endinterface

/* File: src/spcd_param_dec.sv */
// decode of the serial parameter byte into uart settings
`timescale 1ns/1ns
`include "spcd_defs.svh"
module spcd_param_dec (
    input wire logic [7:0] prm,
    output logic [3:0] data_bits,
    output logic stop_two,
    output logic parity_en,
    output logic [1:0] parity_type,
    output logic valid
);
    always_comb begin
        data_bits = (prm[`SPCD_DW_MSB:`SPCD_DW_LSB] == `SPCD_DW_8) ? `SPCD_BITS8 : `SPCD_BITS7;
        stop_two = prm[`SPCD_STOP_BIT];
        parity_en = prm[`SPCD_PEN_BIT];
        parity_type = prm[`SPCD_PT_MSB:`SPCD_PT_LSB];
        // widths 5 and 6 have no code, so codes 00 and 01 are refused
        valid = (prm[`SPCD_RSV_MSB:`SPCD_RSV_LSB] == `SPCD_RSV_ZERO)
            && ((prm[`SPCD_DW_MSB:`SPCD_DW_LSB] == `SPCD_DW_7)
            || (prm[`SPCD_DW_MSB:`SPCD_DW_LSB] == `SPCD_DW_8));
    end
endmodule

/* File: src/spcd_ahb_slave.sv */
// ahb-lite slave with one wait state for every transfer
`timescale 1ns/1ns
`include "spcd_defs.svh"
module spcd_ahb_slave (
    input wire logic clock,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    spcd_reg_if.bus rif
);
    import spcd_pkg::*;

    spcd_bus_state_e state_ff;
    logic [7:0] addr_ff;
    logic write_ff;
    logic hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic hresp_ff;
    logic accept;

    // htrans[1] marks NONSEQ and SEQ
    assign accept = hsel && htrans[1] && hready;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff <= bus_idle;
            hreadyout_ff <= 1'b1;
        end else if (state_ff == bus_idle) begin
            if (accept) begin
                state_ff <= bus_data;
                hreadyout_ff <= 1'b0;
            end
        end else begin
            state_ff <= bus_idle;
            hreadyout_ff <= 1'b1;
        end
    end

    // only whole-word writes land; narrower ones are dropped
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            addr_ff <= 8'h00;
            write_ff <= 1'b0;
        end else if (state_ff == bus_idle && accept) begin
            addr_ff <= haddr[7:0];
            write_ff <= hwrite && (hsize == `SPCD_HSIZE_WORD);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rif.rd) begin
            hrdata_ff <= rif.rdata;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hresp_ff <= 1'b0;
        end else begin
            hresp_ff <= 1'b0;
        end
    end

    assign rif.wr = (state_ff == bus_data) && write_ff;
    assign rif.rd = (state_ff == bus_data) && !write_ff;
    assign rif.addr = addr_ff;
    assign rif.wdata = hwdata;
    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    a_bus_one_wait: assert property ((state_ff == bus_idle && accept) |=> !hreadyout ##1 hreadyout)
        else $error("bus transfer not finished after one wait state");
endmodule

/* File: dv/spcd_host_model.sv */
// remote host model: sends serial parameter command frames over the byte stream
`timescale 1ns/1ns
module spcd_host_model (
    input wire logic clock,
    output logic net_byte_valid,
    output logic [7:0] net_byte
);
    initial begin
        net_byte_valid = 1'b0;
        net_byte = 8'h00;
    end

    // ==========================================================
    // frame sender
    // sum_err and hdr_err corrupt the frame on purpose; zero sends a clean one
    task automatic send_cmd(input logic [23:0] baud, input logic [7:0] prm,
            input logic [7:0] sum_err, input logic [7:0] hdr_err, input int gap);
        logic [63:0] frm;
        logic [7:0] sum;
        sum = baud[23:16] + baud[15:8] + baud[7:0] + prm + sum_err;
        frm = {8'h55, 8'hAA ^ hdr_err, 8'h55, baud, prm, sum};
        for (int i = 7; i >= 0; i--) begin
            @(posedge clock);
            net_byte_valid <= 1'b1;
            net_byte <= frm[i*8 +: 8];
            // no gap after the sum byte, so the caller sees the load pulse in time
            if (i > 0) begin
                repeat (gap) begin
                    @(posedge clock);
                    net_byte_valid <= 1'b0;
                    net_byte <= ~frm[i*8 +: 8];
                end
            end
        end
        // released line shows the inverse, never a stale copy of the sum
        @(posedge clock);
        net_byte_valid <= 1'b0;
        net_byte <= ~frm[7:0];
    endtask
endmodule

/* File: dv/spcd_top_test.sv */
// self-checking testbench of the serial parameter command decoder
`timescale 1ns/1ns
`include "spcd_defs.svh"
module spcd_top_test;
    typedef struct packed {logic [23:0] baud; logic [7:0] prm; logic good;} spcd_row_s;
    logic clock, nrst, hsel, hwrite, hreadyout, hresp, net_byte_valid;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, uart_parity_type;
    logic [2:0] hsize;
    logic [7:0] net_byte, cur_prm;
    logic [23:0] uart_baud, cur_baud;
    logic [3:0] uart_data_bits;
    logic uart_stop_two, uart_parity_en, uart_cfg_load;
    logic [39:0] cfg_obs;
    int n_tests, miscompares;
    spcd_row_s rows [9] = '{
        '{24'h00_0258, 8'h03, 1'b1}, '{24'h01_C200, 8'h03, 1'b1},
        '{24'h00_2580, 8'h0E, 1'b1}, '{24'h00_4B00, 8'h1B, 1'b1},
        '{24'h00_9600, 8'h2F, 1'b1}, '{24'h03_8400, 8'h3A, 1'b1},
        '{24'h00_1234, 8'h43, 1'b0}, '{24'h00_1234, 8'h01, 1'b0},
        '{24'h00_1234, 8'h00, 1'b0}};

    assign cfg_obs = {7'h00, uart_cfg_load, uart_baud, uart_data_bits, uart_stop_two,
        uart_parity_en, uart_parity_type};

    spcd_top dut (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .net_byte_valid(net_byte_valid), .net_byte(net_byte), .uart_baud(uart_baud),
        .uart_data_bits(uart_data_bits), .uart_stop_two(uart_stop_two),
        .uart_parity_en(uart_parity_en), .uart_parity_type(uart_parity_type),
        .uart_cfg_load(uart_cfg_load));

    spcd_host_model host (.clock(clock), .net_byte_valid(net_byte_valid),
        .net_byte(net_byte));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ==========================================================
    // checking helpers
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [39:0] exp_cfg(input logic ld, input logic [23:0] b,
            input logic [7:0] p);
        logic [3:0] bits;
        bits = (p[1:0] == `SPCD_DW_8) ? `SPCD_BITS8 : `SPCD_BITS7;
        return {7'h00, ld, b, bits, p[2], p[3], p[5:4]};
    endfunction

    // load pulse one cycle after the sum byte, then settings hold
    task automatic cmd_check(input logic good, input logic [23:0] baud, input logic [7:0] prm);
        if (good) begin
            cur_baud = baud;
            cur_prm = prm;
        end
        #1;
        chk(cfg_obs, exp_cfg(good, cur_baud, cur_prm));
        @(posedge clock);
        #1;
        chk(cfg_obs, exp_cfg(1'b0, cur_baud, cur_prm));
    endtask

    // ==========================================================
    // ahb-lite master
    // no local limit: a stuck slave is caught by the watchdog alone
    task automatic wait_rdy();
        do begin
            @(posedge clock);
        end while (hreadyout !== 1'b1);
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            input logic [2:0] sz, output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        hsize <= sz;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
        logic [31:0] rd;
        ahb(1'b1, a, d, sz, rd);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h0000_0000, `SPCD_HSIZE_WORD, rd);
        chk({8'h00, rd & m}, {8'h00, e});
    endtask

    // ==========================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = `SPCD_HSIZE_WORD;
        hwdata = 32'h0000_0000;
        n_tests = 0;
        miscompares = 0;
        cur_baud = `SPCD_RST_BAUD;
        cur_prm = `SPCD_RST_PARAM;
        repeat (3) @(posedge clock);
        #1;
        chk(cfg_obs, exp_cfg(1'b0, cur_baud, cur_prm));
        chk({38'h0, hreadyout, hresp}, 40'h00_0000_0002);
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rd_chk(`SPCD_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0030);
        rd_chk(`SPCD_OFS_PARAM, 32'hFFFF_FFFF, 32'h0000_0003);
        rd_chk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
        // feature off, then on in a non-tcp mode: frames must be ignored; then tcp client and tcp server must decode them
        host.send_cmd(24'h00_2580, 8'h03, 8'h00, 8'h00, 0);
        cmd_check(1'b0, 24'h00_2580, 8'h03);
        wr_reg(`SPCD_OFS_CTRL, 32'h0000_0021, `SPCD_HSIZE_WORD);
        host.send_cmd(24'h00_2580, 8'h03, 8'h00, 8'h00, 0);
        cmd_check(1'b0, 24'h00_2580, 8'h03);
        wr_reg(`SPCD_OFS_CTRL, 32'h0000_0011, `SPCD_HSIZE_WORD);
        host.send_cmd(24'h00_2580, 8'h03, 8'h00, 8'h00, 1);
        cmd_check(1'b1, 24'h00_2580, 8'h03);
        wr_reg(`SPCD_OFS_CTRL, 32'h0000_0031, `SPCD_HSIZE_WORD);
        for (int i = 0; i < 9; i++) begin
            host.send_cmd(rows[i].baud, rows[i].prm, 8'h00, 8'h00, i % 2);
            cmd_check(rows[i].good, rows[i].baud, rows[i].prm);
        end
        // awkward cases: clear counters, bad sum, bad header, back-to-back good
        wr_reg(`SPCD_OFS_CTRL, 32'h0000_0033, `SPCD_HSIZE_WORD);
        host.send_cmd(24'h00_2580, 8'h0E, 8'h01, 8'h00, 0);
        cmd_check(1'b0, 24'h00_2580, 8'h0E);
        rd_chk(`SPCD_OFS_COUNT, 32'hFFFF_FFFF, 32'h0001_0000);
        rd_chk(`SPCD_OFS_STAT, 32'h0000_0023, 32'h0000_0022);
        host.send_cmd(24'h00_2580, 8'h0E, 8'h00, 8'h01, 0);
        cmd_check(1'b0, 24'h00_2580, 8'h0E);
        rd_chk(`SPCD_OFS_STAT, 32'h0000_0003, 32'h0000_0001);
        host.send_cmd(24'h00_4B00, 8'h2F, 8'h00, 8'h00, 0);
        cmd_check(1'b1, 24'h00_4B00, 8'h2F);
        host.send_cmd(24'h00_0258, 8'h1B, 8'h00, 8'h00, 0);
        cmd_check(1'b1, 24'h00_0258, 8'h1B);
        rd_chk(`SPCD_OFS_COUNT, 32'h0000_FFFF, 32'h0000_0002);
        rd_chk(`SPCD_OFS_PARAM, 32'hFFFF_FFFF, 32'h0000_001B);
        // read-only and narrow writes must not land
        wr_reg(`SPCD_OFS_BAUD, 32'hFFFF_FFFF, `SPCD_HSIZE_WORD);
        rd_chk(`SPCD_OFS_BAUD, 32'hFFFF_FFFF, {8'h00, cur_baud});
        wr_reg(`SPCD_OFS_CTRL, 32'h0000_0000, 3'h0);
        rd_chk(`SPCD_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0031);
        // second reset in mid-run
        @(posedge clock);
        nrst <= 1'b0;
        cur_baud = `SPCD_RST_BAUD;
        cur_prm = `SPCD_RST_PARAM;
        #1;
        chk(cfg_obs, exp_cfg(1'b0, cur_baud, cur_prm));
        chk({38'h0, hreadyout, hresp}, 40'h00_0000_0002);
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        host.send_cmd(24'h00_2580, 8'h03, 8'h00, 8'h00, 0);
        cmd_check(1'b0, 24'h00_2580, 8'h03);
        final_report();
    end

    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        $display("ERROR at %0t: watchdog expired", $time);
        final_report();
    end
endmodule
